// ===== common/ptr_pkg.sv
// Purpose: shared constants for the phy transmit status / receive data port
// Assumes: five-bit port addresses, null port code reserved
// Notes: time figures in ns, counts derived from the core clock period
package ptr_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] NULL_ADDR = 5'h1f;
  localparam int DATA_W_WIDE = 16;
  localparam int DATA_W_NARROW = 8;
  localparam int NUM_PORTS = 4;
  localparam logic [4:0] BASE_ADDR = 5'h00;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_THRESHOLD = 12;
  localparam int CORE_CLK_PERIOD_NS = 4;
  localparam int LINK_CLK_MIN_MHZ = 25;
  localparam int LINK_CLK_MAX_MHZ = 50;
  // shortest link clock high or low phase, 10 ns at 50 MHz
  localparam int LINK_HALF_MIN_NS = 1000 / (2 * LINK_CLK_MAX_MHZ);
  localparam int LINK_HALF_MIN_CYC = LINK_HALF_MIN_NS / CORE_CLK_PERIOD_NS;
  localparam logic RST_ENB_N = 1'b1;
  localparam logic RST_ODD_PAR = 1'b0;
endpackage

// ===== design/ptr_buf2.sv
// Purpose: two-entry valid/ready buffer
// Assumes: single clock
// Notes: full when both entries held; in_ready drops only when full
`timescale 1ns/10ps
module ptr_buf2 #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_reg [2];
  logic rd_ptr_reg;
  logic wr_ptr_reg;
  logic [1:0] cnt_reg;
  logic push;
  logic pop;
  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end else if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 2'h1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 2'h1;
      end
    end
  end
endmodule

// ===== design/ptr_port.sv
// Purpose: phy-side transmit availability flags and receive data bus driver
// Assumes: link clock sampled by core_clk; fifo levels and rx words come from core logic
// Notes: rx words are prefetched into a two-entry buffer on core_clk and leave it on link clock rising edges seen after synchronisation
// Behaviour
// - polled flag high while polled fifo fill is below threshold, fifo not full.
// - polled flag low once polled fifo fill reaches threshold.
// - with transmit enable asserted, matching polled address drives the polled flag.
// - polled flag released for null code 1f or foreign address.
// - polled flag only in packet mode; direct flags only in byte mode.
// - byte mode gives one direct flag per port, own fifo only.
// - direct flag rises with room for threshold, falls when threshold reached.
// - an 8-bit receive data bus mode is offered beside 16 bits.
// - receive data valid only with enable asserted and valid port selected.
// - receive data big-endian: 16 bits go out in one word, the 8-bit bus carries bits 15 to 8 only.
// - receive data released whenever receive enable is high.
// - receive data released for null or foreign address after enable deasserted.
// - parity over the whole receive bus, odd or even selectable.
// - parity released under the same conditions as receive data.
// - receive address selects which port's receive fifo is read.
`timescale 1ns/10ps
module ptr_port #(
  parameter int NPORT = ptr_pkg::NUM_PORTS,
  parameter int DW = ptr_pkg::DATA_W_WIDE,
  parameter logic [4:0] BASE = ptr_pkg::BASE_ADDR,
  parameter int THRESH = ptr_pkg::FIFO_THRESHOLD,
  parameter int LVL_W = 6
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // static configuration
  input wire logic byte_mode,
  input wire logic narrow_mode,
  input wire logic odd_parity,
  // transmit fifo fill per port, core side
  input wire logic [NPORT*LVL_W-1:0] tx_level,
  // link transmit side pins
  input wire logic tx_link_clk,
  input wire logic tx_enb_n,
  input wire logic [4:0] tx_addr,
  output logic poll_avail_o,
  output logic poll_avail_oe,
  output logic [NPORT-1:0] direct_avail,
  // link receive side pins
  input wire logic rx_link_clk,
  input wire logic rx_enb_n,
  input wire logic [4:0] rx_addr,
  output logic [DW-1:0] rx_data_o,
  output logic rx_data_oe,
  output logic rx_par_o,
  output logic rx_par_oe,
  // receive words from the core, per port
  input wire logic [NPORT-1:0] rx_word_valid,
  output logic [NPORT-1:0] rx_word_ready,
  input wire logic [NPORT*DW-1:0] rx_word_data
);
  typedef enum logic [2:0] {
    PTR_IDLE = 3'b001,
    PTR_SEL = 3'b010,
    PTR_XFER = 3'b100
  } ptr_rx_state_e;

  // synchronised pins
  logic tclk_s;
  logic tenb_n_s;
  logic [4:0] tadr_s;
  logic rclk_s;
  logic renb_n_s;
  logic [4:0] radr_s;
  ptr_sync2 #(.W(7), .INIT({1'b0, 1'b1, 5'h1f})) u_sync_tx (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .d({tx_link_clk, tx_enb_n, tx_addr}),
    .q({tclk_s, tenb_n_s, tadr_s})
  );
  ptr_sync2 #(.W(7), .INIT({1'b0, 1'b1, 5'h1f})) u_sync_rx (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .d({rx_link_clk, rx_enb_n, rx_addr}),
    .q({rclk_s, renb_n_s, radr_s})
  );

  logic tclk_d_reg;
  logic rclk_d_reg;
  logic t_rise;
  logic r_rise;
  assign t_rise = tclk_s && !tclk_d_reg;
  assign r_rise = rclk_s && !rclk_d_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tclk_d_reg <= 1'b0;
      rclk_d_reg <= 1'b0;
    end else begin
      tclk_d_reg <= tclk_s;
      rclk_d_reg <= rclk_s;
    end
  end

  // per-port availability and address match
  logic [NPORT-1:0] avail;
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_avail
      assign avail[gi] = (tx_level[gi*LVL_W +: LVL_W] < LVL_W'(THRESH));
    end
  endgenerate

  function automatic logic addr_hit(input logic [4:0] a);
    logic [5:0] off;
    off = {1'b0, a} - {1'b0, BASE};
    addr_hit = (a != ptr_pkg::NULL_ADDR) && (a >= BASE) && (off < 6'(NPORT));
  endfunction

  logic [4:0] t_idx;
  logic [4:0] r_idx;
  assign t_idx = tadr_s - BASE;
  assign r_idx = radr_s - BASE;

  // transmit availability outputs, updated on link clock rising edges
  logic poll_reg;
  logic poll_oe_reg;
  logic [NPORT-1:0] direct_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      poll_reg <= 1'b0;
      poll_oe_reg <= 1'b0;
      direct_reg <= '0;
    end else if (t_rise) begin
      if (byte_mode) begin
        direct_reg <= avail;
        poll_oe_reg <= 1'b0;
      end else begin
        direct_reg <= '0;
        // polling only while enable asserted and one of our ports addressed
        poll_oe_reg <= !tenb_n_s && addr_hit(tadr_s);
        poll_reg <= addr_hit(tadr_s) ? avail[t_idx[$clog2(NPORT)-1:0]] : 1'b0;
      end
    end
  end
  assign poll_avail_o = poll_reg;
  assign poll_avail_oe = poll_oe_reg;
  assign direct_avail = direct_reg;

  // receive side: selection and output control
  ptr_rx_state_e st_reg;
  logic renb_prev_reg;
  logic [4:0] sel_reg;
  logic sel_ok_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= PTR_IDLE;
      renb_prev_reg <= ptr_pkg::RST_ENB_N;
      sel_reg <= ptr_pkg::NULL_ADDR;
      sel_ok_reg <= 1'b0;
    end else if (r_rise) begin
      renb_prev_reg <= renb_n_s;
      // address is taken as a selection when enable was deasserted last cycle
      if (renb_prev_reg) begin
        sel_reg <= r_idx;
        sel_ok_reg <= addr_hit(radr_s);
      end
      case (st_reg)
        PTR_IDLE: begin
          st_reg <= renb_n_s ? PTR_SEL : PTR_IDLE;
        end
        PTR_SEL: begin
          st_reg <= renb_n_s ? PTR_SEL : PTR_XFER;
        end
        PTR_XFER: begin
          st_reg <= renb_n_s ? PTR_SEL : PTR_XFER;
        end
        default: begin
          st_reg <= PTR_IDLE;
        end
      endcase
    end
  end
  // a selection made at this edge already governs this edge, so a null or
  // foreign address presented after a deasserted enable never drives the bus
  logic sel_ok_now;
  assign sel_ok_now = renb_prev_reg ? addr_hit(radr_s) : sel_ok_reg;

  // buffered words from the selected port
  logic [$clog2(NPORT)-1:0] psel;
  logic [DW-1:0] buf_in_data;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [DW-1:0] buf_out_data;
  logic drive_now;
  assign psel = sel_reg[$clog2(NPORT)-1:0];
  assign buf_in_valid = sel_ok_reg && rx_word_valid[psel];
  assign buf_in_data = rx_word_data[psel*DW +: DW];
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_rdy
      assign rx_word_ready[gi] = buf_in_ready && sel_ok_reg && (psel == gi);
    end
  endgenerate
  ptr_buf2 #(.W(DW)) u_buf (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );
  // a word leaves the buffer on each link rising edge with enable asserted and port valid
  assign drive_now = r_rise && !renb_n_s && sel_ok_now && buf_out_valid;
  assign buf_out_ready = drive_now;

  logic [DW-1:0] data_reg;
  logic par_reg;
  logic oe_reg;
  logic [DW-1:0] data_next;
  always_comb begin
    data_next = buf_out_data;
    if (narrow_mode) begin
      // narrow bus keeps the first byte in the low lane
      data_next = {{(DW-8){1'b0}}, buf_out_data[DW-1 -: 8]};
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_reg <= '0;
      par_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (r_rise) begin
      oe_reg <= !renb_n_s && sel_ok_now;
      if (drive_now) begin
        data_reg <= data_next;
        par_reg <= (^data_next) ^ odd_parity;
      end
    end
  end
  assign rx_data_o = data_reg;
  assign rx_data_oe = oe_reg;
  assign rx_par_o = par_reg;
  assign rx_par_oe = oe_reg;

  poll_released_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (t_rise && (tadr_s == 5'h1f)) |=> !poll_avail_oe)
    else $error("polled flag driven for null address");
  poll_not_byte_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    byte_mode && $stable(byte_mode) && $past(byte_mode) |=> !poll_avail_oe)
    else $error("polled flag driven in byte mode");
  direct_zero_pkt_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (t_rise && !byte_mode) |=> (direct_avail == '0))
    else $error("direct flags active in packet mode");
  direct_follows_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (t_rise && byte_mode) |=> (direct_avail == $past(avail)))
    else $error("direct flag does not follow its fifo");
  poll_value_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (t_rise && !byte_mode && !tenb_n_s && addr_hit(tadr_s))
    |=> poll_avail_oe && (poll_avail_o == $past(avail[t_idx[$clog2(NPORT)-1:0]])))
    else $error("polled flag wrong for addressed port");
  rx_release_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (r_rise && renb_n_s) |=> !rx_data_oe && !rx_par_oe)
    else $error("receive bus driven with enable high");
  rx_null_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (r_rise && renb_prev_reg && (radr_s == 5'h1f)) ##1 (!r_rise) [*1]
    |-> !sel_ok_reg)
    else $error("null address selected a port");
  rx_parity_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    drive_now |=> (rx_par_o == ((^rx_data_o) ^ odd_parity)))
    else $error("receive parity wrong");
  rx_valid_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    buf_out_ready |=> (rx_data_oe && rx_par_oe))
    else $error("word read without valid selection");
  rx_foreign_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (r_rise && renb_prev_reg && !addr_hit(radr_s)) |=> !rx_data_oe)
    else $error("receive bus driven for unselected address");
  rx_phase_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    rx_data_oe |-> (st_reg != PTR_SEL))
    else $error("receive bus driven in selection phase");

  poll_seen_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    poll_avail_oe && poll_avail_o);
  direct_seen_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    byte_mode && (direct_avail != '0));
  rx_word_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    drive_now ##[1:40] drive_now);
  buf_full_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    !buf_in_ready);
endmodule

// ===== design/ptr_sync2.sv
// Purpose: two flip-flop synchroniser for a vector of levels
// Assumes: each bit is independent
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
module ptr_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= INIT;
      q <= INIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ===== dv/ptr_link_model.sv
// Purpose: link-layer partner driving link clocks, enables and addresses
// Assumes: link clocks run free, pins change just after a link falling edge
// Notes: each cycle task returns 30 ns after its sampled rising edge, outputs settled
`timescale 1ns/10ps
module ptr_link_model (
  // link transmit side
  output logic tx_link_clk,
  output logic tx_enb_n,
  output logic [4:0] tx_addr,
  // link receive side
  output logic rx_link_clk,
  output logic rx_enb_n,
  output logic [4:0] rx_addr
);
  initial begin
    tx_link_clk = 1'b0;
    tx_enb_n = 1'b1;
    tx_addr = 5'h1f;
    forever #62.5 tx_link_clk = ~tx_link_clk;
  end

  initial begin
    rx_link_clk = 1'b0;
    rx_enb_n = 1'b1;
    rx_addr = 5'h1f;
    #30;
    forever #62.5 rx_link_clk = ~rx_link_clk;
  end

  // enable is active low and qualifies the address; pins move half a link
  // cycle away from the rising edge that the oversampling phy picks up
  task automatic tx_cycle(input logic enb_n, input logic [4:0] addr);
    @(negedge tx_link_clk);
    #0.5;
    tx_enb_n = enb_n;
    tx_addr = addr;
    @(posedge tx_link_clk);
    #30;
  endtask

  // select with enable high, then read with enable low
  task automatic rx_cycle(input logic enb_n, input logic [4:0] addr);
    @(negedge rx_link_clk);
    #0.5;
    rx_enb_n = enb_n;
    rx_addr = addr;
    @(posedge rx_link_clk);
    #30;
  endtask
endmodule

// ===== dv/tb_top.sv
// Purpose: self-checking bench for the phy status and receive data port
// Assumes: default parameters, threshold from the package
// Notes: port 1 supplies receive words that count up on each accept
`timescale 1ns/10ps
module tb_top;
  logic core_clk;
  logic arst_n;
  logic byte_mode;
  logic narrow_mode;
  logic odd_parity;
  logic [23:0] tx_level;
  logic tx_link_clk;
  logic tx_enb_n;
  logic [4:0] tx_addr;
  logic poll_avail_o;
  logic poll_avail_oe;
  logic [3:0] direct_avail;
  logic rx_link_clk;
  logic rx_enb_n;
  logic [4:0] rx_addr;
  logic [15:0] rx_data_o;
  logic rx_data_oe;
  logic rx_par_o;
  logic rx_par_oe;
  logic [3:0] rx_word_valid;
  logic [3:0] rx_word_ready;
  logic [63:0] rx_word_data;
  int failures;
  int tests_run;
  int accepts;

  ptr_port uut (.core_clk(core_clk), .arst_n(arst_n), .byte_mode(byte_mode),
    .narrow_mode(narrow_mode), .odd_parity(odd_parity), .tx_level(tx_level),
    .tx_link_clk(tx_link_clk), .tx_enb_n(tx_enb_n), .tx_addr(tx_addr),
    .poll_avail_o(poll_avail_o), .poll_avail_oe(poll_avail_oe), .direct_avail(direct_avail),
    .rx_link_clk(rx_link_clk), .rx_enb_n(rx_enb_n), .rx_addr(rx_addr), .rx_data_o(rx_data_o),
    .rx_data_oe(rx_data_oe), .rx_par_o(rx_par_o), .rx_par_oe(rx_par_oe),
    .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready), .rx_word_data(rx_word_data));

  ptr_link_model link (.tx_link_clk(tx_link_clk), .tx_enb_n(tx_enb_n), .tx_addr(tx_addr),
    .rx_link_clk(rx_link_clk), .rx_enb_n(rx_enb_n), .rx_addr(rx_addr));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // next word of port 1 appears after each accept
  always @(posedge core_clk) begin
    if (rx_word_valid[1] && rx_word_ready[1]) begin
      accepts <= accepts + 1;
      rx_word_data[31:16] <= rx_word_data[31:16] + 16'h0001;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // reset with new static settings, port 1 offers words afterwards
  task automatic cfg(input logic bm, input logic nm, input logic op);
    @(posedge core_clk);
    #1;
    arst_n = 1'b0;
    byte_mode = bm;
    narrow_mode = nm;
    odd_parity = op;
    rx_word_valid = 4'h0;
    rx_word_data[31:16] = 16'ha5c3;
    accepts = 0;
    repeat (6) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    rx_word_valid = 4'h2;
  endtask

  task automatic poll_test();
    cfg(1'b0, 1'b0, 1'b0);
    tx_level = {6'd11, 6'd12, 6'd0, 6'd13};
    for (int p = 0; p < 4; p++) begin
      link.tx_cycle(1'b0, 5'(p));
      check(16'(poll_avail_oe), 16'h1);
      check(16'(poll_avail_o), 16'(tx_level[p*6 +: 6] < ptr_pkg::FIFO_THRESHOLD));
    end
    link.tx_cycle(1'b1, 5'h01);
    check(16'(poll_avail_oe), 16'h0);
    link.tx_cycle(1'b0, 5'h1f);
    check(16'(poll_avail_oe), 16'h0);
    link.tx_cycle(1'b0, 5'h04);
    check(16'(poll_avail_oe), 16'h0);
    check(16'(direct_avail), 16'h0);
    $display("poll test done");
  endtask

  task automatic direct_test();
    cfg(1'b1, 1'b0, 1'b0);
    tx_level = {6'd12, 6'd5, 6'd11, 6'd40};
    link.tx_cycle(1'b0, 5'h00);
    check(16'(direct_avail), 16'h6);
    check(16'(poll_avail_oe), 16'h0);
    tx_level[17:12] = 6'd12;
    tx_level[23:18] = 6'd11;
    link.tx_cycle(1'b0, 5'h00);
    check(16'(direct_avail), 16'ha);
    $display("direct test done");
  endtask

  task automatic rx_test(input logic nm, input logic op);
    logic [15:0] w;
    cfg(1'b0, nm, op);
    link.rx_cycle(1'b1, 5'h01);
    link.rx_cycle(1'b1, 5'h01);
    check(16'(accepts), 16'h2);
    check(16'(rx_data_oe), 16'h0);
    for (int i = 0; i < 3; i++) begin
      link.rx_cycle(1'b0, 5'h01);
      w = 16'ha5c3 + 16'(i);
      if (nm) begin
        w = {8'h00, w[15:8]};
      end
      check(16'(rx_data_oe), 16'h1);
      check(rx_data_o, w);
      check(16'(rx_par_o), 16'(^w ^ op));
      check(16'(rx_par_oe), 16'h1);
    end
    link.rx_cycle(1'b1, 5'h1f);
    check(16'(rx_par_oe), 16'h0);
    link.rx_cycle(1'b0, 5'h1f);
    check(16'(rx_data_oe), 16'h0);
    check(16'(rx_par_oe), 16'h0);
    link.rx_cycle(1'b1, 5'h07);
    link.rx_cycle(1'b0, 5'h07);
    check(16'(rx_data_oe), 16'h0);
    check(16'(accepts), 16'h5);
    $display("rx test done");
  endtask

  initial begin
    arst_n = 1'b0;
    byte_mode = 1'b0;
    narrow_mode = 1'b0;
    odd_parity = 1'b0;
    tx_level = '0;
    rx_word_valid = 4'h0;
    rx_word_data = 64'h0123_4567_89ab_cdef;
    failures = 0;
    tests_run = 0;
    accepts = 0;
    poll_test();
    direct_test();
    rx_test(1'b0, 1'b0);
    rx_test(1'b0, 1'b1);
    rx_test(1'b1, 1'b0);
    tally_and_finish();
  end

  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
endmodule
